// ### rtl/tlip_controller.sv
`timescale 1ns/1ps
module tlip_controller
   import tlip_pkg::*;
#(
   parameter int          NUM_SRC  = 8,
   parameter int          ADDR_W   = 12,
   parameter logic [63:0] SRC_PAGE = 64'h0000_0000_0000_0000
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   input  wire logic [NUM_SRC-1:0] src_req,
   input  wire logic              instr_boundary,
   input  wire logic              return_done,
   output logic                   core_stall,
   output logic                   isr_entry,
   output logic [2:0]             isr_vector,
   output logic [7:0]             page_in_use,
   output logic                   irq
);

   // ----------------------------------------------------------------
   // State.
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0]       page;
      logic [7:0]       page_next;
      logic [7:0]       page_last;
      logic             auto_page;
      logic [7:0]       int_en;
      logic [7:0]       int_pri;
      logic [EVT_W-1:0] evt_status;
      logic [EVT_W-1:0] evt_mask;
      tlip_state_t      state;
      logic [2:0]       call_cnt;
      logic [2:0]       call_src;
      logic             call_hi;
      logic             act_hi;
      logic             act_lo;
      logic             pushed_hi;
      logic             pushed_lo;
      logic             hold_one;
      logic             wr_pend;
      logic [7:0]       wr_idx;
      logic [31:0]      rdata;
      logic             entry;
      logic [2:0]       vector;
   } tlip_regs_t;

   tlip_regs_t r;
   tlip_regs_t next_r;

   // ----------------------------------------------------------------
   // Priority decode, every cycle.
   // ----------------------------------------------------------------
   logic [NUM_SRC-1:0] pend_hi;
   logic [NUM_SRC-1:0] pend_lo;
   logic [2:0]         win_hi;
   logic [2:0]         win_lo;
   logic               any_hi;
   logic               any_lo;

   always_comb begin
      pend_hi = src_req & r.int_en[NUM_SRC-1:0] & r.int_pri[NUM_SRC-1:0];
      pend_lo = src_req & r.int_en[NUM_SRC-1:0] & ~r.int_pri[NUM_SRC-1:0];
      win_hi  = 3'h0;
      win_lo  = 3'h0;
      any_hi  = 1'b0;
      any_lo  = 1'b0;
      // Scanning downward leaves the lowest index as the winner.
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pend_hi[i]) begin
            win_hi = 3'(i);
            any_hi = 1'b1;
         end
         if (pend_lo[i]) begin
            win_lo = 3'(i);
            any_lo = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Next state.
   // ----------------------------------------------------------------
   logic           addr_ok;
   logic [7:0]     addr_idx;
   logic [7:0]     wbyte;
   logic           take_hi;
   logic           take_lo;
   logic           may_take;
   logic [EVT_W-1:0] evt_set;
   logic [EVT_W-1:0] evt_clr;
   logic [7:0]     rd_byte;
   logic [7:0]     src_page;

   always_comb begin
      next_r   = r;
      addr_ok  = hsel && htrans == HTRANS_NONSEQ && hready;
      addr_idx = haddr[9:2];
      wbyte    = hwdata[7:0];
      evt_set  = '0;
      evt_clr  = '0;
      rd_byte  = BYTE_RESET;
      src_page = PAGE_RESET;
      next_r.entry = 1'b0;

      // The instruction ending with a return never takes a call, nor does the one after it when that return closed a level.
      may_take = r.state == TLIP_IDLE && instr_boundary && !return_done && !r.hold_one;
      take_hi  = may_take && any_hi && !r.act_hi;
      take_lo  = may_take && !take_hi && any_lo && !r.act_hi && !r.act_lo;

      if (r.hold_one && instr_boundary && !return_done) begin
         next_r.hold_one = 1'b0;
      end

      case (r.state)
         TLIP_IDLE: begin
            if (take_hi || take_lo) begin
               // This cycle is the detect cycle; four call cycles follow.
               next_r.state    = TLIP_CALL;
               next_r.call_cnt = CALL_LAST;
               next_r.call_hi  = take_hi;
               next_r.call_src = take_hi ? win_hi : win_lo;
            end
         end
         TLIP_CALL: begin
            if (r.call_cnt == 3'h0) begin
               next_r.state  = TLIP_IDLE;
               next_r.entry  = 1'b1;
               next_r.vector = r.call_src;
               evt_set[EVT_ENTRY_BIT] = 1'b1;
               src_page = SRC_PAGE[{r.call_src, 3'h0} +: 8];
               if (r.call_hi) begin
                  next_r.act_hi    = 1'b1;
                  next_r.pushed_hi = r.auto_page;
               end else begin
                  next_r.act_lo    = 1'b1;
                  next_r.pushed_lo = r.auto_page;
               end
               if (r.auto_page) begin
                  next_r.page_last = r.page_next;
                  next_r.page_next = r.page;
                  next_r.page      = src_page;
               end
            end else begin
               next_r.call_cnt = r.call_cnt - 3'h1;
            end
         end
         default: begin
            next_r.state = TLIP_IDLE;
         end
      endcase

      // A return closes the innermost running level.
      if (return_done && (r.act_hi || r.act_lo)) begin
         next_r.hold_one = 1'b1;
         evt_set[EVT_RETURN_BIT] = 1'b1;
         if (r.act_hi) begin
            next_r.act_hi    = 1'b0;
            next_r.pushed_hi = 1'b0;
         end else begin
            next_r.act_lo    = 1'b0;
            next_r.pushed_lo = 1'b0;
         end
         // Whatever software left in the stack is what comes back.
         if (r.act_hi ? r.pushed_hi : r.pushed_lo) begin
            next_r.page      = r.page_next;
            next_r.page_next = r.page_last;
         end
      end

      // Bus data phase: the write lands after any push or pop of this cycle.
      if (r.wr_pend) begin
         next_r.wr_pend = 1'b0;
         if (r.wr_idx == IDX_PAGE_SEL) begin
            next_r.page = wbyte;
         end else if (r.wr_idx == IDX_PAGE_CTRL) begin
            next_r.auto_page = wbyte[CTRL_AUTO_BIT];
         end else if (r.wr_idx == IDX_PAGE_NEXT) begin
            next_r.page_next = wbyte;
         end else if (r.wr_idx == IDX_PAGE_LAST) begin
            next_r.page_last = wbyte;
         end else if (r.wr_idx == IDX_INT_EN) begin
            next_r.int_en = wbyte;
         end else if (r.wr_idx == IDX_INT_PRI) begin
            next_r.int_pri = wbyte;
         end else if (r.wr_idx == IDX_EVT_STATUS) begin
            evt_clr = wbyte[EVT_W-1:0];
         end else if (r.wr_idx == IDX_EVT_MASK) begin
            next_r.evt_mask = wbyte[EVT_W-1:0];
         end
      end

      // A new event wins over a clear written in the same cycle.
      next_r.evt_status = (r.evt_status & ~evt_clr) | evt_set;

      if (addr_ok) begin
         next_r.wr_pend = hwrite;
         next_r.wr_idx  = addr_idx;
      end

      // Read data comes from the next state so a write just before is seen.
      if (addr_idx == IDX_PAGE_SEL) begin
         rd_byte = next_r.page;
      end else if (addr_idx == IDX_PAGE_CTRL) begin
         rd_byte = {7'h00, next_r.auto_page};
      end else if (addr_idx == IDX_PAGE_NEXT) begin
         rd_byte = next_r.page_next;
      end else if (addr_idx == IDX_PAGE_LAST) begin
         rd_byte = next_r.page_last;
      end else if (addr_idx == IDX_INT_EN) begin
         rd_byte = next_r.int_en;
      end else if (addr_idx == IDX_INT_PRI) begin
         rd_byte = next_r.int_pri;
      end else if (addr_idx == IDX_EVT_STATUS) begin
         rd_byte = {6'h00, next_r.evt_status};
      end else if (addr_idx == IDX_EVT_MASK) begin
         rd_byte = {6'h00, next_r.evt_mask};
      end else if (addr_idx == IDX_CORE_STATE) begin
         rd_byte = {4'h0, next_r.hold_one, next_r.state == TLIP_CALL, next_r.act_hi, next_r.act_lo};
      end
      if (addr_ok && !hwrite) begin
         next_r.rdata = {24'h000000, rd_byte};
      end
   end

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r.page       <= PAGE_RESET;
         r.page_next  <= PAGE_RESET;
         r.page_last  <= PAGE_RESET;
         r.auto_page  <= 1'b0;
         r.int_en     <= BYTE_RESET;
         r.int_pri    <= PRI_RESET;
         r.evt_status <= '0;
         r.evt_mask   <= '0;
         r.state      <= TLIP_IDLE;
         r.call_cnt   <= 3'h0;
         r.call_src   <= 3'h0;
         r.call_hi    <= 1'b0;
         r.act_hi     <= 1'b0;
         r.act_lo     <= 1'b0;
         r.pushed_hi  <= 1'b0;
         r.pushed_lo  <= 1'b0;
         r.hold_one   <= 1'b0;
         r.wr_pend    <= 1'b0;
         r.wr_idx     <= 8'h00;
         r.rdata      <= 32'h0000_0000;
         r.entry      <= 1'b0;
         r.vector     <= 3'h0;
      end else begin
         r <= next_r;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign hreadyout   = 1'b1;
   assign hresp       = HRESP_OKAY;
   assign hrdata      = r.rdata;
   assign core_stall  = r.state == TLIP_CALL;
   assign isr_entry   = r.entry;
   assign isr_vector  = r.vector;
   assign page_in_use = r.page;
   assign irq         = |(r.evt_status & r.evt_mask);

endmodule // tlip_controller

// ### rtl/tlip_pkg.sv
package tlip_pkg;

   // ----------------------------------------------------------------
   // Register indices; the byte address is four times the index.
   // ----------------------------------------------------------------
   localparam logic [7:0] IDX_PAGE_CTRL  = 8'h84;
   localparam logic [7:0] IDX_PAGE_NEXT  = 8'h85;
   localparam logic [7:0] IDX_PAGE_LAST  = 8'h86;
   localparam logic [7:0] IDX_PAGE_SEL   = 8'ha7;
   localparam logic [7:0] IDX_INT_EN     = 8'ha8;
   localparam logic [7:0] IDX_INT_PRI    = 8'hb8;
   localparam logic [7:0] IDX_EVT_STATUS = 8'he0;
   localparam logic [7:0] IDX_EVT_MASK   = 8'he1;
   localparam logic [7:0] IDX_CORE_STATE = 8'he2;

   // ----------------------------------------------------------------
   // Field positions and reset values.
   // ----------------------------------------------------------------
   localparam int         CTRL_AUTO_BIT  = 0;
   localparam int         EVT_ENTRY_BIT  = 0;
   localparam int         EVT_RETURN_BIT = 1;
   localparam int         EVT_W          = 2;
   localparam int         ST_ACT_LO_BIT  = 0;
   localparam int         ST_ACT_HI_BIT  = 1;
   localparam int         ST_CALL_BIT    = 2;
   localparam int         ST_HOLD_BIT    = 3;
   localparam logic [7:0] PAGE_RESET     = 8'h00;
   localparam logic [7:0] BYTE_RESET     = 8'h00;
   localparam logic [7:0] PRI_RESET      = 8'h00;

   // ----------------------------------------------------------------
   // Timing in system clock cycles.
   // ----------------------------------------------------------------
   localparam int         DETECT_CYCLES  = 1;
   localparam int         CALL_CYCLES    = 4;
   localparam int         RETURN_CYCLES  = 5;
   localparam int         DIVIDE_CYCLES  = 8;
   localparam int         WORST_CYCLES   = DETECT_CYCLES + RETURN_CYCLES + DIVIDE_CYCLES + CALL_CYCLES;
   localparam logic [2:0] CALL_LAST      = 3'(CALL_CYCLES - 1);

   localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
   localparam logic       HRESP_OKAY     = 1'b0;

   typedef enum logic [0:0] {
      TLIP_IDLE,
      TLIP_CALL
   } tlip_state_t;

endpackage

// ### verif/tlip_checker_sva.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Port-level checks of the interrupt controller.
// ------------------------------------------------------------------
module tlip_checker
   import tlip_pkg::*;
(
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hsel,
   input wire logic [1:0] htrans,
   input wire logic       hwrite,
   input wire logic       hready,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       instr_boundary,
   input wire logic       return_done,
   input wire logic       core_stall,
   input wire logic       isr_entry,
   input wire logic [2:0] isr_vector,
   input wire logic [7:0] page_in_use
);
   logic wr_addr;
   assign wr_addr = hsel && hwrite && hready && (htrans == HTRANS_NONSEQ);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // The vector call occupies exactly four cycles before the routine starts.
   sequence call_s;
      core_stall [*4] ##1 (!core_stall && isr_entry);
   endsequence
   call_len_a: assert property ($rose(core_stall) |-> call_s)
      else $error("vector call length wrong");
   entry_pulse_a: assert property (isr_entry |=> !isr_entry)
      else $error("entry pulse longer than one cycle");
   detect_cause_a: assert property ($rose(core_stall) |-> $past(instr_boundary) && !$past(return_done))
      else $error("call started without a boundary");
   ret_refuse_a: assert property (return_done |=> !$rose(core_stall))
      else $error("call taken in the return cycle");
   held_instr_a: assert property (return_done ##1 instr_boundary |=> !$rose(core_stall))
      else $error("instruction after return skipped");
   bus_okay_a: assert property (hreadyout && (hresp == HRESP_OKAY))
      else $error("bus answer not ready or not okay");
   vector_hold_a: assert property (!isr_entry |-> $stable(isr_vector))
      else $error("vector moved without entry");
   page_cause_a: assert property ($changed(page_in_use) |-> isr_entry || $past(return_done) || $past(wr_addr, 2))
      else $error("page moved without entry, return or write");
endmodule // tlip_checker

bind tlip_controller tlip_checker i_tlip_checker (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .instr_boundary(instr_boundary), .return_done(return_done),
   .core_stall(core_stall), .isr_entry(isr_entry), .isr_vector(isr_vector), .page_in_use(page_in_use));

// ### verif/tlip_core_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Core stand-in: retires one instruction every gap cycles.
// ------------------------------------------------------------------
module tlip_core_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       core_stall,
   input  wire logic       do_ret,
   input  wire logic [3:0] gap,
   output logic            instr_boundary,
   output logic            return_done
);
   logic [3:0] cnt;
   logic       ret_pend;
   // A return is only issued in an instruction slot, never during a call.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt            <= 4'h0;
         ret_pend       <= 1'b0;
         instr_boundary <= 1'b0;
         return_done    <= 1'b0;
      end else begin
         instr_boundary <= 1'b0;
         return_done    <= 1'b0;
         ret_pend       <= ret_pend | do_ret;
         if (core_stall) begin
            cnt <= 4'h0;
         end else if (cnt + 4'h1 >= gap) begin
            cnt            <= 4'h0;
            return_done    <= ret_pend;
            instr_boundary <= !ret_pend;
            ret_pend       <= do_ret;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule // tlip_core_model

// ### verif/testbench.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Register, priority and page stack scenarios.
// ------------------------------------------------------------------
module testbench import tlip_pkg::*; ;
   localparam int WAIT_MAX = 30;
   logic        hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, do_ret = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0, hrdata, rd;
   logic [7:0]  src_req = 8'h00, page_in_use;
   logic [3:0]  gap = 4'h1;
   logic [2:0]  isr_vector;
   logic        hreadyout, hresp, instr_boundary, return_done, core_stall, isr_entry, irq;
   int          fails = 0, checks = 0, cyc = 0, n;

   tlip_controller #(.SRC_PAGE(64'h0000_5500_3300_1100)) i_tlip_controller (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .src_req(src_req), .instr_boundary(instr_boundary), .return_done(return_done),
      .core_stall(core_stall), .isr_entry(isr_entry), .isr_vector(isr_vector),
      .page_in_use(page_in_use), .irq(irq));
   tlip_core_model i_tlip_core_model (
      .hclk(hclk), .hresetn(hresetn), .core_stall(core_stall), .do_ret(do_ret), .gap(gap),
      .instr_boundary(instr_boundary), .return_done(return_done));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         fails++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One single word transfer; the address phase is held until hready is seen.
   task automatic xfer(input logic [7:0] idx, input logic wr, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {2'b00, idx, 2'b00};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic do_return();
      @(posedge hclk);
      do_ret <= 1'b1;
      @(posedge hclk);
      do_ret <= 1'b0;
      do @(negedge hclk); while (return_done !== 1'b1);
   endtask
   // Counts cycles from the caller's cycle, index zero, to the entry pulse.
   task automatic wait_entry();
      n = -1;
      do begin
         @(negedge hclk);
         n++;
      end while (isr_entry !== 1'b1 && n < WAIT_MAX);
   endtask

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      xfer(IDX_PAGE_SEL, 1'b0, 32'h0);
      chk("page reset", {24'h0, PAGE_RESET}, rd);
      xfer(IDX_INT_PRI, 1'b0, 32'h0);
      chk("priority reset", {24'h0, PRI_RESET}, rd);
      xfer(8'h10, 1'b1, 32'hff);
      xfer(8'h10, 1'b0, 32'h0);
      chk("unmapped", 32'h0, rd);
      xfer(IDX_PAGE_SEL, 1'b1, 32'h07);
      xfer(IDX_PAGE_SEL, 1'b0, 32'h0);
      chk("page select", 32'h07, rd);
      xfer(IDX_PAGE_NEXT, 1'b0, 32'h0);
      chk("no push on write", 32'h0, rd);
      xfer(IDX_INT_EN, 1'b1, 32'h2a);
      xfer(IDX_INT_PRI, 1'b1, 32'h20);
      xfer(IDX_PAGE_CTRL, 1'b1, 32'h01);
      src_req <= 8'h08;
      wait_entry();
      chk("fast latency", DETECT_CYCLES + CALL_CYCLES, n);
      chk("page on entry", 32'h33, {24'h0, page_in_use});
      chk("irq masked", 32'h0, {31'h0, irq});
      @(posedge hclk);
      src_req <= 8'h00;
      xfer(IDX_EVT_MASK, 1'b1, 32'h01);
      xfer(IDX_EVT_STATUS, 1'b0, 32'h0);
      chk("entry event", 32'h01, rd);
      chk("irq raised", 32'h1, {31'h0, irq});
      xfer(IDX_EVT_STATUS, 1'b1, 32'h01);
      xfer(IDX_EVT_STATUS, 1'b0, 32'h0);
      chk("irq cleared", 32'h0, {31'h0, irq});
      do_return();
      @(negedge hclk);
      chk("page restored", 32'h07, {24'h0, page_in_use});
      @(posedge hclk);
      src_req <= 8'h2a;
      wait_entry();
      chk("high first", 32'h5, {29'h0, isr_vector});
      xfer(IDX_PAGE_NEXT, 1'b0, 32'h0);
      chk("stack next", 32'h07, rd);
      src_req <= 8'h0a;
      wait_entry();
      chk("high not preempted", WAIT_MAX, n);
      xfer(IDX_CORE_STATE, 1'b0, 32'h0);
      chk("core state", 32'h02, rd);
      do_return();
      // The one instruction after the return retires before detection.
      wait_entry();
      chk("held latency", 1 + DETECT_CYCLES + CALL_CYCLES, n);
      chk("same level order", 32'h1, {29'h0, isr_vector});
      chk("low page", 32'h11, {24'h0, page_in_use});
      @(posedge hclk);
      src_req <= 8'h08;
      xfer(IDX_PAGE_NEXT, 1'b1, 32'h0c);
      do_return();
      @(negedge hclk);
      chk("altered stack", 32'h0c, {24'h0, page_in_use});
      wait_entry();
      @(posedge hclk);
      src_req <= 8'h20;
      wait_entry();
      chk("high preempts low", DETECT_CYCLES + CALL_CYCLES, n);
      chk("preempt vector", 32'h5, {29'h0, isr_vector});
      conclude();
   end
endmodule // testbench
